// file: hw/rlr_alu.sv
// Rotate-left-no-carry and rotate-right-through-carry datapath
`timescale 1ns/1ps
`default_nettype none
`include "rlr_regs.svh"
module rlr_alu (
	// Clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	// Decoder side
	input  wire logic        start_i,
	input  wire logic        op_sel_i,
	input  wire logic        dest_i,
	input  wire logic        access_i,
	input  wire logic [7:0]  faddr_i,
	input  wire logic        ext_en_i,
	input  wire logic [3:0]  bank_select_reg_i,
	input  wire logic [11:0] index_base_i,
	// Data memory side
	output logic [11:0]      mem_addr_o,
	output logic             mem_rd_o,
	input  wire logic [7:0]  mem_rdata_i,
	output logic             mem_wr_o,
	output logic [7:0]       result_o,
	output logic             wreg_we_o,
	// Status flags
	input  wire logic        carry_i,
	output logic             carry_o,
	output logic             carry_we_o,
	output logic             negative_o,
	output logic             zero_o,
	output logic             flags_we_o,
	// Phase view
	output logic             busy_o,
	output logic             ready_o
);
	rlr_pkg::rlr_state_type r;       // Registered state
	rlr_pkg::rlr_state_type next_r;  // Next state

	// Access bank address: low RAM or upper special bank
	function automatic logic [11:0] access_addr(input logic [7:0] f);
		if (f < `RLR_ACCESS_SPLIT) begin
			access_addr = {`RLR_LOW_BANK, f};
		end else begin
			access_addr = {`RLR_SFR_BANK, f};
		end
	endfunction

	// Left rotate, carry untouched
	function automatic logic [7:0] rot_left(input logic [7:0] v);
		rot_left = {v[6:0], v[7]};
	endfunction

	// Right rotate through carry, nine bits in all
	function automatic logic [8:0] rot_right_c(input logic [7:0] v, input logic c);
		rot_right_c = {c, v[7:0]};
	endfunction

	// New accepts only when idle or in the last phase, so back to back works
	assign ready_o = (r.phase == rlr_pkg::PH_IDLE) || (r.phase == rlr_pkg::PH_Q4);

	// Next state
	always_comb begin
		next_r          = r;
		next_r.mem_we   = 1'b0;
		next_r.wreg_we  = 1'b0;
		next_r.flags_we = 1'b0;
		next_r.carry_we = 1'b0;
		case (r.phase)
			rlr_pkg::PH_IDLE, rlr_pkg::PH_Q4: begin
				// Q1 decode: latch instruction fields
				if (start_i) begin
					next_r.phase   = rlr_pkg::PH_Q1;
					next_r.op      = rlr_pkg::rlr_op_type'(op_sel_i);
					next_r.dest    = dest_i;
					next_r.access  = access_i;
					next_r.faddr   = faddr_i;
					next_r.indexed = ext_en_i && !access_i
						&& (faddr_i <= `RLR_INDEX_LIMIT);
					if (access_i) begin
						next_r.addr = {bank_select_reg_i, faddr_i};
					end else if (ext_en_i && (faddr_i <= `RLR_INDEX_LIMIT)) begin
						next_r.addr = index_base_i + {4'h0, faddr_i};
					end else begin
						next_r.addr = access_addr(faddr_i);
					end
				end else begin
					next_r.phase = rlr_pkg::PH_IDLE;
				end
			end
			rlr_pkg::PH_Q1: begin
				// Decode done, read next
				next_r.phase = rlr_pkg::PH_Q2;
			end
			rlr_pkg::PH_Q2: begin
				// Read operand; carry sampled here, so a prior write has landed
				next_r.operand = mem_rdata_i;
				next_r.cin     = carry_i;
				next_r.phase   = rlr_pkg::PH_Q3;
			end
			rlr_pkg::PH_Q3: begin
				// Process data
				if (r.op == rlr_pkg::ROTATE_LEFT_NO_CARRY_OP) begin
					next_r.result   = rot_left(r.operand);
					next_r.cout     = r.cin;               // Carry passes through untouched
					next_r.carry_we = 1'b0;
				end else begin
					{next_r.result, next_r.cout} = rot_right_c(r.operand, r.cin);
					next_r.carry_we = 1'b1;
				end
				next_r.negative = next_r.result[`RLR_SIGN_BIT];
				next_r.zero     = (next_r.result == `RLR_BYTE_ZERO);
				next_r.flags_we = 1'b1;
				next_r.mem_we   = r.dest;
				next_r.wreg_we  = !r.dest;
				next_r.phase    = rlr_pkg::PH_Q4;
			end
			default: begin
				next_r.phase = rlr_pkg::PH_IDLE;
			end
		endcase
	end

	// State register; enable low freezes everything
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r          <= '0;
			r.phase    <= rlr_pkg::PH_IDLE;
			r.addr     <= `RLR_ADDR_ZERO;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	// Outputs straight from state; write strobes gated so a frozen cycle writes nothing twice
	assign mem_addr_o = r.addr;
	assign mem_rd_o   = (r.phase == rlr_pkg::PH_Q2);
	assign mem_wr_o   = r.mem_we && ce_i;
	assign wreg_we_o  = r.wreg_we && ce_i;
	assign result_o   = r.result;
	assign carry_o    = r.cout;
	assign carry_we_o = r.carry_we && ce_i;
	assign negative_o = r.negative;
	assign zero_o     = r.zero;
	assign flags_we_o = r.flags_we && ce_i;
	assign busy_o     = (r.phase != rlr_pkg::PH_IDLE);

	// Checks
	// Left rotate moves every bit up and leaves carry alone
	property p_rot_left;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(flags_we_o && r.op == rlr_pkg::ROTATE_LEFT_NO_CARRY_OP)
		|-> result_o == {r.operand[6:0], r.operand[7]} && !carry_we_o;
	endproperty
	a_rot_left: assert property (p_rot_left) else $error("left rotate wrong");
	// Top bit comes round to the bottom
	property p_rot_wrap;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(flags_we_o && r.op == rlr_pkg::ROTATE_LEFT_NO_CARRY_OP)
		|-> result_o[0] == r.operand[7];
	endproperty
	a_rot_wrap: assert property (p_rot_wrap) else $error("bit 7 not wrapped");
	// Right rotate shifts down and always writes carry
	property p_rot_right;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(flags_we_o && r.op == rlr_pkg::ROTATE_RIGHT_CARRY_OP)
		|-> carry_we_o && result_o[6:0] == r.operand[7:1];
	endproperty
	a_rot_right: assert property (p_rot_right) else $error("right rotate wrong");
	// Old carry enters the top, bottom bit leaves as carry
	property p_rot_carry;
		@(posedge mclk_i) disable iff (!rst_b_i)
		carry_we_o |-> carry_o == r.operand[0] && result_o[7] == r.cin;
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("carry path wrong");
	// Exactly one destination strobe, chosen by the select bit
	property p_dest_w;
		@(posedge mclk_i) disable iff (!rst_b_i)
		flags_we_o |-> (wreg_we_o == !r.dest) && (mem_wr_o == r.dest);
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("working register select wrong");
	// Write back lands where the operand was read
	property p_dest_f;
		@(posedge mclk_i) disable iff (!rst_b_i || !ce_i)
		mem_rd_o ##1 ce_i ##1 mem_wr_o |-> mem_addr_o == $past(mem_addr_o, 2);
	endproperty
	a_dest_f: assert property (p_dest_f) else $error("write back address moved");
	// Access bank path ignores the bank select register
	property p_access;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mem_rd_o && !r.access && !r.indexed) |-> mem_addr_o == access_addr(r.faddr);
	endproperty
	a_access: assert property (p_access) else $error("access bank address wrong");
	// Banked path keeps the file address in the low byte
	property p_banked;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(mem_rd_o && r.access) |-> mem_addr_o[7:0] == r.faddr && !r.indexed;
	endproperty
	a_banked: assert property (p_banked) else $error("banked address wrong");
	// Indexed mode adds the file address to the base, 12 bit wrap
	property p_indexed;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(ready_o && ce_i && start_i && ext_en_i && !access_i && faddr_i <= `RLR_INDEX_LIMIT)
		|=> r.indexed && mem_addr_o == $past(index_base_i) + {4'h0, $past(faddr_i)};
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");
	// Read two cycles after the take, strobes two after the read
	property p_phases;
		@(posedge mclk_i) disable iff (!rst_b_i || !ce_i)
		(ready_o && start_i) |=> ##1 mem_rd_o ##2 flags_we_o;
	endproperty
	a_phases: assert property (p_phases) else $error("phase sequence wrong");
	// Flags follow the result on every rotate
	property p_flags;
		@(posedge mclk_i) disable iff (!rst_b_i)
		flags_we_o |-> negative_o == result_o[7] && zero_o == (result_o == 8'h00);
	endproperty
	a_flags: assert property (p_flags) else $error("flag values wrong");
	// Enable low holds every bit of state, so a stalled core loses nothing
	property p_freeze;
		@(posedge mclk_i) disable iff (!rst_b_i)
		!ce_i |=> r == $past(r);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule
`default_nettype wire

// file: inc/rlr_regs.svh
// Constants of the rotate datapath: address map figures and field positions
// Operation
// - Rotate left ignores carry flag entirely
// - Bit 7 wraps to bit 0
// - Rotate right uses carry as ninth bit
// - Bit 0 to carry, old carry to 7
// - Destination zero writes working register only
// - Destination one writes back source register
// - Access zero uses fixed access bank
// - Access one prepends bank select register
// - Extended set, low addresses use indexed offset
// - One word, four phases, one cycle
`ifndef RLR_REGS_SVH
`define RLR_REGS_SVH
// Access bank split: file addresses below this sit in low RAM
`define RLR_ACCESS_SPLIT 8'h60
// Highest file address handled by indexed literal offset mode
`define RLR_INDEX_LIMIT 8'h5F
// Bank holding the upper half of the access bank
`define RLR_SFR_BANK 4'hF
// Bank holding the lower half of the access bank
`define RLR_LOW_BANK 4'h0
// Sign bit of a byte result
`define RLR_SIGN_BIT 7
// Cleared byte value
`define RLR_BYTE_ZERO 8'h00
// Cleared data memory address
`define RLR_ADDR_ZERO 12'h000
`endif

// file: inc/rlr_pkg.sv
// Types shared by the rotate datapath
package rlr_pkg;
	// Instruction phase, one clock each
	typedef enum logic [4:0] {
		PH_IDLE = 5'b0_0001,
		PH_Q1   = 5'b0_0010,
		PH_Q2   = 5'b0_0100,
		PH_Q3   = 5'b0_1000,
		PH_Q4   = 5'b1_0000
	} rlr_phase_type;
	// Operation select
	typedef enum logic {
		ROTATE_LEFT_NO_CARRY_OP = 1'b0,
		ROTATE_RIGHT_CARRY_OP   = 1'b1
	} rlr_op_type;
	// Whole state of the datapath
	typedef struct packed {
		rlr_phase_type phase;     // Current phase
		rlr_op_type    op;        // Latched operation
		logic          dest;      // Latched destination select
		logic          access;    // Latched access select
		logic          indexed;   // Indexed literal offset in use
		logic [7:0]    faddr;     // Latched file address
		logic [11:0]   addr;      // Resolved data memory address
		logic [7:0]    operand;   // Operand read in Q2
		logic          cin;       // Carry captured in Q2
		logic [7:0]    result;    // Rotated byte
		logic          cout;      // Carry produced
		logic          negative;  // Negative flag value
		logic          zero;      // Zero flag value
		logic          mem_we;    // Write back strobe
		logic          wreg_we;   // Working register strobe
		logic          flags_we;  // N and Z strobe
		logic          carry_we;  // Carry strobe
	} rlr_state_type;
endpackage

// file: tb/rlr_mem_model.sv
// Data memory model facing the rotate datapath
`timescale 1ns/1ps
`default_nettype none
module rlr_mem_model (
	// Clock
	input  wire logic        mclk_i,
	// Datapath side
	input  wire logic [11:0] addr_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [7:0]  wdata_i,
	output logic [7:0]       rdata_o
);
	logic [7:0] mem [0:4095]; // Byte store
	logic [7:0] last = 8'h00; // Last value on the read bus
	// Seed pattern, repeating every 256 addresses
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i * 37 + 11);
		end
	end
	// Outside a read the bus toggles, so a late sample never passes by luck
	assign rdata_o = rd_i ? mem[addr_i] : ~last;
	// Write back and bus history
	always @(posedge mclk_i) begin
		if (wr_i) begin
			mem[addr_i] <= wdata_i;
		end
		last <= rdata_o;
	end
endmodule
`default_nettype wire

// file: tb/tb_rotate_left_right_alu.sv
// Self-checking bench of the rotate datapath
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_left_right_alu;
	logic        mclk_i = 0, rst_b_i = 0, start_i = 0, op_sel_i = 0, dest_i = 0;
	logic        access_i = 0, ext_en_i = 0, carry_i = 0, ce_i = 1;
	logic [7:0]  faddr_i = 8'h00, mem_rdata_i, result_o;
	logic [3:0]  bank_select_reg_i = 4'h0;
	logic [11:0] index_base_i = 12'h000, mem_addr_o;
	logic        mem_rd_o, mem_wr_o, wreg_we_o, carry_o, carry_we_o;
	logic        negative_o, zero_o, flags_we_o, busy_o, ready_o;
	int          mismatches = 0, n_checks = 0;
	// Clock, 10 ns period
	always #5 mclk_i = ~mclk_i;
	rlr_alu i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .start_i(start_i),
		.op_sel_i(op_sel_i), .dest_i(dest_i), .access_i(access_i), .faddr_i(faddr_i),
		.ext_en_i(ext_en_i), .bank_select_reg_i(bank_select_reg_i),
		.index_base_i(index_base_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
		.mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .result_o(result_o),
		.wreg_we_o(wreg_we_o), .carry_i(carry_i), .carry_o(carry_o),
		.carry_we_o(carry_we_o), .negative_o(negative_o), .zero_o(zero_o),
		.flags_we_o(flags_we_o), .busy_o(busy_o), .ready_o(ready_o));
	rlr_mem_model i_mem (.mclk_i(mclk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
		.wr_i(mem_wr_o), .wdata_i(result_o), .rdata_o(mem_rdata_i));
	// One comparison
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask
	// One instruction, walked phase by phase; stall freezes Q4 for one cycle,
	// b2b issues in the Q4 of the call before, leave returns while still in Q4
	task automatic run(input logic op, d, a, ext, input logic [7:0] f,
		input logic [3:0] b, input logic [11:0] base, input logic c, input logic [11:0] ea,
		input logic stall, b2b, leave);
		logic [7:0] o;
		logic [7:0] r;
		o = i_mem.mem[ea];
		r = op ? {c, o[7:1]} : {o[6:0], o[7]};
		if (!b2b) begin
			@(posedge mclk_i); #1;
		end
		chk(ready_o, 1, "ready to take");
		start_i = 1; op_sel_i = op; dest_i = d; access_i = a; ext_en_i = ext;
		faddr_i = f; bank_select_reg_i = b; index_base_i = base; carry_i = c;
		@(posedge mclk_i); #1;
		start_i = 0;
		chk(mem_addr_o, ea, "address");
		chk(ready_o, 0, "ready in Q1");
		chk(busy_o, 1, "busy in Q1");
		@(posedge mclk_i); #1;
		chk(mem_rd_o, 1, "read in Q2");
		@(posedge mclk_i); #1;
		chk(mem_rd_o, 0, "read after Q2");
		@(posedge mclk_i); #1;
		chk(result_o, r, "result");
		chk(flags_we_o, 1, "flag strobe");
		chk(negative_o, r[7], "negative");
		chk(zero_o, r == 8'h00, "zero");
		chk(carry_we_o, op, "carry strobe");
		if (op) chk(carry_o, o[0], "carry out");
		chk(mem_wr_o, d, "write back strobe");
		chk(wreg_we_o, !d, "working strobe");
		// Enable low in Q4: phase held, strobes gated, nothing written
		if (stall) begin
			ce_i = 0;
			@(posedge mclk_i); #1;
			chk(busy_o, 1, "frozen in Q4");
			chk(mem_wr_o, 0, "write strobe gated");
			chk(flags_we_o, 0, "flag strobe gated");
			chk(i_mem.mem[ea], o, "no write while frozen");
			ce_i = 1;
		end
		if (!leave) begin
			@(posedge mclk_i); #1;
			chk(i_mem.mem[ea], d ? r : o, "memory after");
			chk(flags_we_o, 0, "strobe length");
			chk(busy_o, 0, "idle after Q4");
		end
		$display("test done: op %0d dest %0d addr %h", op, d, ea);
	endtask
	// Verdict
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Hang guard, far beyond the roughly 60 cycles needed
	initial begin
		#20000;
		mismatches++;
		$display("MISMATCH at %0t: watchdog", $time);
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk_i);
		#1;
		chk(ready_o, 1, "ready in reset");
		rst_b_i = 1;
		run(0, 1, 0, 0, 8'h10, 4'h3, 12'h000, 1, 12'h010, 0, 0, 0);
		run(0, 0, 1, 0, 8'h80, 4'h3, 12'h000, 0, 12'h380, 0, 0, 0);
		run(1, 0, 0, 0, 8'h80, 4'h3, 12'h000, 1, 12'hF80, 0, 0, 0);
		run(1, 1, 0, 1, 8'h5F, 4'h3, 12'h200, 0, 12'h25F, 1, 0, 0);
		run(1, 1, 0, 1, 8'h60, 4'h3, 12'h200, 1, 12'hF60, 0, 0, 0);
		run(0, 0, 0, 1, 8'h05, 4'h3, 12'hFFE, 1, 12'h003, 0, 0, 0);
		run(1, 0, 0, 0, 8'h3E, 4'h3, 12'h000, 0, 12'h03E, 0, 0, 0);
		run(0, 0, 0, 0, 8'h20, 4'h3, 12'h000, 0, 12'h020, 0, 0, 1);
		run(1, 1, 1, 0, 8'h44, 4'h5, 12'h000, 1, 12'h544, 0, 1, 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
